// ---- rtl/rm_pkg.sv ----
// Constants shared by the registered 16 x 16 multiplier block.
// Assumes an APB slave with 8-bit byte addresses and 32-bit data.
//
// Contract
// - The block takes two separate 16-bit operand ports and drives results on one 16-bit product port.
// - Each operand is read as signed two's complement or unsigned, giving signed, unsigned or mixed products.
// - The full product is 32 bits wide, split into an upper and a lower 16-bit half held in separate registers.
// - The half-select control low puts the upper half on the product port, high puts the lower half.
// - The lower half can be fed back through the Y operand port, put on the product port, or both.
// - Rounding adds one at the top bit of the lower half so the upper half is a rounded result; under format adjust the code adds it at the upper LSB.
// - Format adjust on a signed product shifts the upper half and the lower top bit left and repeats the sign there.
// - Bypass passes the half picked by the half-select around the product registers, through one pin flop, to the output drivers.
// - With the pipeline stage on, an internal register splits the array to cut the result interval from 65 ns to 35 ns.
// - In independent-clock mode each of the four registers loads on its own load line.
// - In single-clock mode three enables load the X register, the Y register and the product pair as one unit.
// - Operand and product registers capture only on a rising edge.
package rm_pkg;
   localparam int OP_W = 16;
   localparam int PROD_W = 32;
   localparam int AW = 8;
   // Register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_OPX = 8'h04;
   localparam logic [7:0] OFF_OPY = 8'h08;
   localparam logic [7:0] OFF_PROD = 8'h0C;
   localparam logic [7:0] OFF_LOAD = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   // Control register fields
   localparam int CB_XSIGNED = 0;
   localparam int CB_YSIGNED = 1;
   localparam int CB_ROUND = 2;
   localparam int CB_FMTADJ = 3;
   localparam int CB_BYPASS = 4;
   localparam int CB_PIPE = 5;
   localparam int CB_LOWSEL = 6;
   localparam int CB_FEEDBACK = 7;
   localparam int CB_INDEP = 8;
   localparam int CB_DRIVE = 9;
   localparam int CTRL_W = 10;
   localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
   // Load strobe fields, shared by the load register and the load lines
   localparam int LB_X = 0;
   localparam int LB_Y = 1;
   localparam int LB_MSP = 2;
   localparam int LB_LSP = 3;
   localparam int LD_W = 4;
   // Rounding weight: one at the top bit of the lower half
   localparam logic [PROD_W-1:0] ROUND_ADD = 32'h0000_8000;
   // This build carries the optional internal pipeline stage
   localparam logic HAS_PIPE = 1'b1;
   // Timing, in ns, and the cycle counts at the 20 MHz bus clock
   localparam int CLK_NS = 50;
   localparam int MULT_NS = 65;
   localparam int PIPE_NS = 35;
   localparam int MULT_CYC = (MULT_NS + CLK_NS - 1) / CLK_NS;
   localparam int PIPE_CYC = (PIPE_NS + CLK_NS - 1) / CLK_NS;
   localparam int BUSY_W = 2;
endpackage

// ---- rtl/rm_array.sv ----
// Multiplier array with format, rounding, format adjust and optional stage.
// Operands come from registers on the same clock; output is combinational.
`timescale 1ns/10ps
`default_nettype none
module rm_array
   import rm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [OP_W-1:0] x,
   input wire logic [OP_W-1:0] y,
   input wire logic x_signed,
   input wire logic y_signed,
   input wire logic round_control,
   input wire logic format_adjust,
   input wire logic pipe_on,
   output logic [PROD_W-1:0] prod
);
   logic signed [OP_W:0] xe;
   logic signed [OP_W:0] ye;
   logic signed [2*OP_W+1:0] full;
   logic [PROD_W-1:0] raw;
   logic [PROD_W-1:0] pipe_q;
   logic [PROD_W-1:0] base;
   logic [PROD_W-1:0] rnd;

   // Sign or zero extension per operand, then one signed multiply
   assign xe = {x_signed & x[OP_W-1], x};
   assign ye = {y_signed & y[OP_W-1], y};
   assign full = xe * ye;
   assign raw = full[PROD_W-1:0];

   // Mid-array stage; captures every cycle so throughput is one per clock
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pipe_q <= '0;
      else
         pipe_q <= raw;
   end

   assign base = (pipe_on && HAS_PIPE) ? pipe_q : raw;
   assign rnd = round_control ? base + ROUND_ADD : base;

   // Format adjust only makes sense when the product carries a sign
   always_comb
   begin
      if (format_adjust && (x_signed || y_signed))
         prod = {rnd[PROD_W-2:OP_W-1], rnd[PROD_W-1], rnd[OP_W-2:0]};
      else
         prod = rnd;
   end

   chk_unsigned_mult: assert property (@(posedge pclk) disable iff (!presetn)
      (!x_signed && !y_signed && !round_control && !pipe_on)
      |-> prod == {16'h0000, x} * {16'h0000, y})
      else $error("unsigned product wrong");
   chk_pipe_delay: assert property (@(posedge pclk) disable iff (!presetn)
      (pipe_on && !round_control && !format_adjust && $stable(x) && $stable(y))
      |-> prod == $past(raw))
      else $error("pipeline stage did not delay product by one cycle");
   chk_round_add: assert property (@(posedge pclk) disable iff (!presetn)
      (round_control && !format_adjust && !pipe_on)
      |-> prod == raw + ROUND_ADD)
      else $error("rounding did not add at lower half top bit");
   chk_fmt_shift: assert property (@(posedge pclk) disable iff (!presetn)
      (format_adjust && x_signed && !round_control && !pipe_on)
      |-> (prod[31:16] == raw[30:15]) && (prod[15] == raw[31]))
      else $error("format adjust shift wrong");
endmodule
`default_nettype wire

// ---- rtl/rm_prod_reg.sv ----
// Upper and lower product half registers with separate load enables.
// Enables are one-cycle pulses or levels built on the same clock.
`timescale 1ns/10ps
`default_nettype none
module rm_prod_reg
   import rm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [PROD_W-1:0] d,
   input wire logic msp_en,
   input wire logic lsp_en,
   output logic [OP_W-1:0] upper_product_half_q,
   output logic [OP_W-1:0] lower_product_half_q
);
   // Upper half
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         upper_product_half_q <= '0;
      else if (msp_en)
         upper_product_half_q <= d[PROD_W-1:OP_W];
   end

   // Lower half
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         lower_product_half_q <= '0;
      else if (lsp_en)
         lower_product_half_q <= d[OP_W-1:0];
   end

   chk_halves_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (!msp_en && !lsp_en) |=> $stable(upper_product_half_q) && $stable(lower_product_half_q))
      else $error("product half changed without load");
endmodule
`default_nettype wire

// ---- rtl/rm_mult16.sv ----
// Top of the registered multiplier: APB registers, pin synchronisers,
// operand and product registers, output steering and three-state pins.
// Assumes all pins arrive from outside pclk and an APB master on pclk.
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module rm_mult16
   import rm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [OP_W-1:0] x_pin,
   input wire logic [OP_W-1:0] y_pin_in,
   output logic [OP_W-1:0] y_pin_out,
   output logic y_pin_oe_n,
   input wire logic [LD_W-1:0] load_pin,
   output logic [OP_W-1:0] prod_pin_out,
   output logic prod_pin_oe_n
);
   localparam int SYNC_W = LD_W + 2 * OP_W;

   logic [CTRL_W-1:0] ctrl_q;
   logic [LD_W-1:0] sw_load_q;
   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync2_q;
   logic [LD_W-1:0] line_prev_q;
   logic [LD_W-1:0] line_lvl;
   logic [LD_W-1:0] line_go;
   logic [LD_W-1:0] ld;
   logic [OP_W-1:0] x_s;
   logic [OP_W-1:0] y_s;
   logic [OP_W-1:0] x_q;
   logic [OP_W-1:0] y_q;
   logic [OP_W-1:0] y_d;
   logic [PROD_W-1:0] prod_comb;
   logic [OP_W-1:0] upper_q;
   logic [OP_W-1:0] lower_q;
   logic msp_en;
   logic lsp_en;
   logic [BUSY_W-1:0] busy_q;
   logic [31:0] rd_d;
   logic hit;
   logic setup;
   logic access;
   logic indep;

   assign indep = ctrl_q[CB_INDEP];

   // Two-flop synchroniser for load lines and both operand buses
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync1_q <= '0;
         sync2_q <= '0;
      end
      else
      begin
         sync1_q <= {load_pin, y_pin_in, x_pin};
         sync2_q <= sync1_q;
      end
   end

   assign x_s = sync2_q[OP_W-1:0];
   assign y_s = sync2_q[2*OP_W-1:OP_W];
   assign line_lvl = sync2_q[SYNC_W-1:2*OP_W];

   // Previous line level for rising-edge detection; reads stage two only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         line_prev_q <= '0;
      else
         line_prev_q <= line_lvl;
   end

   // Each line acts as a clock in independent mode, as an enable otherwise
   genvar gi;
   generate
      for (gi = 0; gi < LD_W; gi++)
      begin : g_line
         assign line_go[gi] = indep ? (line_lvl[gi] & ~line_prev_q[gi])
                                    : line_lvl[gi];
         assign ld[gi] = line_go[gi] | sw_load_q[gi];
      end
   endgenerate

   // Product pair moves as one unit unless each half has its own line
   assign msp_en = ld[LB_MSP];
   assign lsp_en = indep ? ld[LB_LSP] : ld[LB_MSP];

   // Feedback takes the lower half in place of the Y bus
   assign y_d = ctrl_q[CB_FEEDBACK] ? lower_q : y_s;

   // Operand X register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         x_q <= '0;
      else if (ld[LB_X])
         x_q <= x_s;
   end

   // Operand Y register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         y_q <= '0;
      else if (ld[LB_Y])
         y_q <= y_d;
   end

   rm_array u_array (
      .pclk(pclk),
      .presetn(presetn),
      .x(x_q),
      .y(y_q),
      .x_signed(ctrl_q[CB_XSIGNED]),
      .y_signed(ctrl_q[CB_YSIGNED]),
      .round_control(ctrl_q[CB_ROUND]),
      .format_adjust(ctrl_q[CB_FMTADJ]),
      .pipe_on(ctrl_q[CB_PIPE]),
      .prod(prod_comb)
   );

   rm_prod_reg u_prod (
      .pclk(pclk),
      .presetn(presetn),
      .d(prod_comb),
      .msp_en(msp_en),
      .lsp_en(lsp_en),
      .upper_product_half_q(upper_q),
      .lower_product_half_q(lower_q)
   );

   // Result settle counter after an operand load; whole cycles, rounded up
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         busy_q <= '0;
      else if (ld[LB_X] || ld[LB_Y])
         busy_q <= ctrl_q[CB_PIPE] ? BUSY_W'(PIPE_CYC) : BUSY_W'(MULT_CYC);
      else if (busy_q != '0)
         busy_q <= busy_q - 1'b1;
   end

   // Product port; bypass takes the array output, the output still
   // passes one pin flop so the port never glitches mid-cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prod_pin_out <= '0;
      else if (ctrl_q[CB_BYPASS])
         prod_pin_out <= ctrl_q[CB_LOWSEL] ? prod_comb[OP_W-1:0]
                                           : prod_comb[PROD_W-1:OP_W];
      else
         prod_pin_out <= ctrl_q[CB_LOWSEL] ? lower_q : upper_q;
   end

   // Output enables are low while driving; release avoids bus contention
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prod_pin_oe_n <= 1'b1;
         y_pin_oe_n <= 1'b1;
         y_pin_out <= '0;
      end
      else
      begin
         prod_pin_oe_n <= ~ctrl_q[CB_DRIVE];
         y_pin_oe_n <= ~ctrl_q[CB_FEEDBACK];
         y_pin_out <= lower_q;
      end
   end

   // APB phases: answer in the first access cycle, no wait states
   assign setup = psel & ~penable;
   assign access = psel & penable & pready;

   // Address decode and read data
   always_comb
   begin
      hit = 1'b1;
      rd_d = '0;
      case (paddr)
         OFF_CTRL: rd_d[CTRL_W-1:0] = ctrl_q;
         OFF_OPX: rd_d[OP_W-1:0] = x_q;
         OFF_OPY: rd_d[OP_W-1:0] = y_q;
         OFF_PROD: rd_d = {upper_q, lower_q};
         OFF_LOAD: rd_d = '0;
         OFF_STATUS: rd_d[BUSY_W-1:0] = busy_q;
         default: hit = 1'b0;
      endcase
   end

   // Answer registered in setup so bus outputs come from flops
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready <= setup;
         prdata <= (setup && !pwrite) ? rd_d : '0;
         pslverr <= setup & ~hit;
      end
   end

   // Control register write
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_q <= CTRL_RST;
      else if (access && pwrite && paddr == OFF_CTRL)
         ctrl_q <= pwdata[CTRL_W-1:0];
   end

   // Software load strobes last exactly one cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sw_load_q <= '0;
      else if (access && pwrite && paddr == OFF_LOAD)
         sw_load_q <= pwdata[LD_W-1:0];
      else
         sw_load_q <= '0;
   end

   chk_out_upper: assert property (@(posedge pclk) disable iff (!presetn)
      (!ctrl_q[CB_BYPASS] && !ctrl_q[CB_LOWSEL]) |=> prod_pin_out == $past(upper_q))
      else $error("upper half not steered to product port");
   chk_out_lower: assert property (@(posedge pclk) disable iff (!presetn)
      (!ctrl_q[CB_BYPASS] && ctrl_q[CB_LOWSEL]) |=> prod_pin_out == $past(lower_q))
      else $error("lower half not steered to product port");
   chk_bypass_flow: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl_q[CB_BYPASS] && !ctrl_q[CB_LOWSEL])
      |=> prod_pin_out == $past(prod_comb[31:16]))
      else $error("bypass did not pass array output");
   chk_pair_load: assert property (@(posedge pclk) disable iff (!presetn)
      (!indep && line_lvl[LB_MSP])
      |=> (upper_q == $past(prod_comb[31:16])) && (lower_q == $past(prod_comb[15:0])))
      else $error("product pair did not load as one unit");
   chk_x_edge_load: assert property (@(posedge pclk) disable iff (!presetn)
      (indep && line_lvl[LB_X] && !line_prev_q[LB_X]) |=> x_q == $past(x_s))
      else $error("X register missed its load edge");
   chk_x_level_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (indep && line_lvl[LB_X] && line_prev_q[LB_X] && !sw_load_q[LB_X]) |=> $stable(x_q))
      else $error("X register loaded on a high level");
   chk_lsp_indep_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (indep && !ld[LB_LSP]) |=> $stable(lower_q))
      else $error("lower half changed without its load");
   chk_fb_drive: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_q[CB_FEEDBACK] |=> !y_pin_oe_n && (y_pin_out == $past(lower_q)))
      else $error("lower half not driven on Y port");
   chk_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
      (setup) |=> pready ##1 !pready)
      else $error("APB answer not one cycle after setup");

   cov_indep_mult: cover property (@(posedge pclk) disable iff (!presetn)
      indep && ld[LB_X] ##[1:8] ld[LB_Y] ##[1:8] msp_en);
   cov_pair_pipe: cover property (@(posedge pclk) disable iff (!presetn)
      !indep && ctrl_q[CB_PIPE] && msp_en);
   cov_feedback: cover property (@(posedge pclk) disable iff (!presetn)
      ctrl_q[CB_FEEDBACK] && ld[LB_Y]);
   cov_bypass_round: cover property (@(posedge pclk) disable iff (!presetn)
      ctrl_q[CB_BYPASS] && ctrl_q[CB_ROUND]);
   cov_sw_load: cover property (@(posedge pclk) disable iff (!presetn)
      !indep && sw_load_q[LB_MSP]);

   // Pin drivers, lower bypass, settle count and one-cycle software loads
   chk_prod_drive: assert property (@(posedge pclk) disable iff (!presetn)
      ctrl_q[CB_DRIVE] |=> !prod_pin_oe_n)
      else $error("product port not driven when enabled");
   chk_bypass_low: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl_q[CB_BYPASS] && ctrl_q[CB_LOWSEL])
      |=> prod_pin_out == $past(prod_comb[OP_W-1:0]))
      else $error("bypass did not pass lower array half");
   chk_settle_load: assert property (@(posedge pclk) disable iff (!presetn)
      (ld[LB_X] || ld[LB_Y])
      |=> busy_q == ($past(ctrl_q[CB_PIPE]) ? BUSY_W'(PIPE_CYC) : BUSY_W'(MULT_CYC)))
      else $error("settle count not started by operand load");
   chk_pair_enables: assert property (@(posedge pclk) disable iff (!presetn)
      !indep |-> lsp_en == msp_en)
      else $error("product halves not loaded as one unit");
   chk_y_fb_load: assert property (@(posedge pclk) disable iff (!presetn)
      (ld[LB_Y] && ctrl_q[CB_FEEDBACK]) |=> y_q == $past(lower_q))
      else $error("Y register missed the fed back lower half");
   chk_sw_load_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      (sw_load_q != '0) |=> sw_load_q == '0)
      else $error("software load strobe longer than one cycle");
   chk_slverr_pair: assert property (@(posedge pclk) disable iff (!presetn)
      pslverr |-> pready)
      else $error("error flag without ready");
endmodule
`default_nettype wire

// ---- tb/rm_bus_model.sv ----
// Far-side datapath bus model: drives operands and load lines,
// resolves the shared Y wire and watches the product port.
// Assumes the block samples every pin on pclk through synchronisers.
`timescale 1ns/10ps
`default_nettype none
module rm_bus_model
   import rm_pkg::*;
(
   input wire logic pclk,
   output logic [OP_W-1:0] x_pin,
   output logic [OP_W-1:0] y_pin_in,
   input wire logic [OP_W-1:0] y_pin_out,
   input wire logic y_pin_oe_n,
   output logic [LD_W-1:0] load_pin,
   input wire logic [OP_W-1:0] prod_pin_out,
   input wire logic prod_pin_oe_n,
   output logic [OP_W-1:0] prod_seen
);
   logic [OP_W-1:0] y_drv;
   logic y_drv_en;
   logic [OP_W-1:0] y_last;
   logic [OP_W-1:0] p_last;

   // No pull on either bus: a released wire shows the inverse of its last value
   assign y_pin_in = !y_pin_oe_n ? y_pin_out : (y_drv_en ? y_drv : ~y_last);
   assign prod_seen = !prod_pin_oe_n ? prod_pin_out : ~p_last;

   // Remember what each wire last carried while driven
   always @(posedge pclk)
   begin
      if (!y_pin_oe_n || y_drv_en)
         y_last <= y_pin_in;
      if (!prod_pin_oe_n)
         p_last <= prod_pin_out;
   end

   initial
   begin
      x_pin = '0;
      y_drv = '0;
      y_drv_en = 1'b1;
      load_pin = '0;
      y_last = '0;
      p_last = '0;
   end

   // Operands stay put until the next call, so one can be held constant
   task automatic put_ops(input logic [OP_W-1:0] xv, input logic [OP_W-1:0] yv,
      input logic drv);
      @(posedge pclk);
      x_pin <= xv;
      y_drv <= yv;
      y_drv_en <= drv;
   endtask

   // Data already stable; line held long enough to clear the synchronisers
   task automatic strobe(input logic [LD_W-1:0] bits);
      repeat (2) @(posedge pclk);
      load_pin <= bits;
      repeat (4) @(posedge pclk);
      load_pin <= '0;
      repeat (6) @(posedge pclk);
   endtask
endmodule
`default_nettype wire

// ---- tb/tb_rm_mult16.sv ----
// Self-checking bench for the registered multiplier top.
// Assumes the APB slave answers with pready and the bus model drives pins.
`timescale 1ns/10ps
`default_nettype none
module tb_rm_mult16;
   import rm_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [AW-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [OP_W-1:0] x_pin, y_pin_in, y_pin_out, prod_pin_out, prod_seen;
   logic y_pin_oe_n, prod_pin_oe_n;
   logic [LD_W-1:0] load_pin;
   logic [31:0] exp_p;
   int miscompares, total_checks;
   localparam logic [31:0] DRV = 32'h1 << CB_DRIVE;
   localparam logic [31:0] LOW = 32'h1 << CB_LOWSEL;

   rm_mult16 dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .x_pin(x_pin), .y_pin_in(y_pin_in),
      .y_pin_out(y_pin_out), .y_pin_oe_n(y_pin_oe_n), .load_pin(load_pin),
      .prod_pin_out(prod_pin_out), .prod_pin_oe_n(prod_pin_oe_n));
   rm_bus_model bus (.pclk(pclk), .x_pin(x_pin), .y_pin_in(y_pin_in),
      .y_pin_out(y_pin_out), .y_pin_oe_n(y_pin_oe_n), .load_pin(load_pin),
      .prod_pin_out(prod_pin_out), .prod_pin_oe_n(prod_pin_oe_n),
      .prod_seen(prod_seen));

   // 20 MHz bus clock
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One APB transfer; request held until pready is sampled high
   task automatic apb(input logic [AW-1:0] a, input logic wr, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         miscompares++;
         test_done();
      end
   endtask

   task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(a, 1'b1, d, r, e);
   endtask

   task automatic rchk(input string name, input logic [AW-1:0] a, input logic [31:0] exp,
      input logic exp_err);
      logic [31:0] r;
      logic e;
      apb(a, 1'b0, 32'h0, r, e);
      check(name, r, exp);
      check({name, "_err"}, {31'h0, e}, {31'h0, exp_err});
   endtask

   // Reference product, each operand signed or unsigned on its own
   function automatic logic [31:0] mul(input logic [15:0] a, input logic [15:0] b,
      input logic sa, input logic sb);
      logic signed [33:0] p;
      p = $signed({sa & a[15], a}) * $signed({sb & b[15], b});
      return p[31:0];
   endfunction

   // Hang guard
   initial
   begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      test_done();
   end

   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      miscompares = 0;
      total_checks = 0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      check("prod_oe_rst", {31'h0, prod_pin_oe_n}, 32'h1);
      check("y_oe_rst", {31'h0, y_pin_oe_n}, 32'h1);
      rchk("ctrl_rst", OFF_CTRL, 32'h0, 1'b0);
      rchk("prod_rst", OFF_PROD, 32'h0, 1'b0);
      rchk("unmapped", 8'h18, 32'h0, 1'b1);
      // Every operand format, both halves on the port
      bus.put_ops(16'hFFFE, 16'h8003, 1'b1);
      for (int i = 0; i < 4; i++)
      begin
         wr(OFF_CTRL, DRV | 32'(i));
         bus.strobe(4'h3);
         bus.strobe(4'h4);
         exp_p = mul(16'hFFFE, 16'h8003, i[0], i[1]);
         rchk("prod_fmt", OFF_PROD, exp_p, 1'b0);
         check("port_upper", prod_seen, exp_p[31:16]);
         wr(OFF_CTRL, DRV | LOW | 32'(i));
         repeat (3) @(posedge pclk);
         check("port_lower", prod_seen, exp_p[15:0]);
      end
      // Rounding then format adjust, operands held constant
      exp_p = mul(16'hFFFE, 16'h8003, 1'b1, 1'b1);
      wr(OFF_CTRL, DRV | 32'h3 | (32'h1 << CB_ROUND));
      bus.strobe(4'h4);
      rchk("round", OFF_PROD, exp_p + ROUND_ADD, 1'b0);
      wr(OFF_CTRL, DRV | 32'h3 | (32'h1 << CB_FMTADJ));
      bus.strobe(4'h4);
      exp_p = {exp_p[30:15], exp_p[31], exp_p[14:0]};
      rchk("fmt_adj", OFF_PROD, exp_p, 1'b0);
      wr(OFF_PROD, 32'hFFFF_FFFF);
      // Operand loads alone leave the product registers alone
      bus.put_ops(16'h0005, 16'h0007, 1'b1);
      bus.strobe(4'h3);
      rchk("prod_hold", OFF_PROD, exp_p, 1'b0);
      rchk("opx", OFF_OPX, 32'h5, 1'b0);
      rchk("opy", OFF_OPY, 32'h7, 1'b0);
      // Bypass shows the new product with no product load
      wr(OFF_CTRL, DRV | LOW | (32'h1 << CB_BYPASS));
      repeat (4) @(posedge pclk);
      check("bypass", prod_seen, 32'h23);
      rchk("byp_reg", OFF_PROD, exp_p, 1'b0);
      // Independent loads: lower half then upper half
      wr(OFF_CTRL, DRV | (32'h1 << CB_INDEP));
      bus.put_ops(16'h0100, 16'h0300, 1'b1);
      bus.strobe(4'h3);
      bus.strobe(4'h8);
      rchk("lsp_only", OFF_PROD, {exp_p[31:16], 16'h0}, 1'b0);
      bus.strobe(4'h4);
      rchk("msp_only", OFF_PROD, 32'h0003_0000, 1'b0);
      // Pipelined array, single clock mode
      wr(OFF_CTRL, DRV | 32'h3 | (32'h1 << CB_PIPE));
      bus.put_ops(16'h8001, 16'h0003, 1'b1);
      bus.strobe(4'h3);
      bus.strobe(4'h4);
      rchk("pipe", OFF_PROD, 32'hFFFE_8003, 1'b0);
      // Lower half driven back into Y, bus model released
      bus.put_ops(16'h0003, 16'h0000, 1'b0);
      wr(OFF_CTRL, DRV | (32'h1 << CB_FEEDBACK));
      repeat (3) @(posedge pclk);
      check("y_oe", {31'h0, y_pin_oe_n}, 32'h0);
      check("y_out", y_pin_out, 32'h8003);
      bus.strobe(4'h3);
      rchk("y_fb", OFF_OPY, 32'h8003, 1'b0);
      bus.strobe(4'h4);
      rchk("fb_prod", OFF_PROD, 32'h0001_8009, 1'b0);
      rchk("load_rd", OFF_LOAD, 32'h0, 1'b0);
      // Software loads and settle count, Y port released again
      wr(OFF_CTRL, DRV);
      bus.put_ops(16'h0002, 16'h0004, 1'b1);
      wr(OFF_LOAD, 32'h3);
      check("y_oe_off", {31'h0, y_pin_oe_n}, 32'h1);
      rchk("status", OFF_STATUS, 32'(MULT_CYC), 1'b0);
      wr(OFF_LOAD, 32'h1 << LB_MSP);
      rchk("sw_pair", OFF_PROD, 32'h0000_0008, 1'b0);
      test_done();
   end
endmodule
`default_nettype wire
